// File: mmsp_defines.svh
// Constants for the multi-mode serial port core
`ifndef MMSP_DEFINES_SVH
`define MMSP_DEFINES_SVH

// ==========================================
// Command codes
`define CMD_REP_START   2'h1
`define CMD_NACK        2'h2
`define CMD_STOP        2'h3

// ==========================================
// Error flag position and count
`define ERR_BUS         4
`define ERR_COUNT       5

// ==========================================
// Reset values and data constants
`define DUMMY_BYTE      8'h00
`define FLAGS_RESET     5'h00
`define BYTE_RESET      8'h00
`define LAST_BIT        3'h7

`endif

// File: serial_port_pkg.sv
// Types shared by the serial port core
package serial_port_pkg;

   // ==========================================
   // Operating modes
   typedef enum logic [2:0] {
      MODE_USART      = 3'b000,
      MODE_SPI_SLAVE  = 3'b001,
      MODE_SPI_MASTER = 3'b010,
      MODE_I2C_SLAVE  = 3'b011,
      MODE_I2C_MASTER = 3'b100
   } mode_t;

   // ==========================================
   // Bus ownership of the two-wire master
   typedef enum logic [0:0] {
      M_IDLE  = 1'b0,
      M_OWNER = 1'b1
   } master_state_t;

endpackage

// File: pin_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
   parameter logic INIT = 1'b0
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Asynchronous input
   input  wire logic pin,
   // Filtered level
   output logic      level
);

   logic stage1;
   logic stage2;
   logic stage3;

   // ==========================================
   // Shift chain; only stage2 reads stage1
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Level follows once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         level <= INIT;
      end else if (stage2 == stage3) begin
         level <= stage3;
      end
   end

endmodule // pin_sync3

`default_nettype wire

// File: multi_mode_serial_port_anomalies.sv
// Multi-mode serial port core with its known corner-case behaviour
`timescale 1ns/1ps
`default_nettype none

`include "mmsp_defines.svh"

module multi_mode_serial_port_anomalies (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // Configuration
   input  wire logic       unit_enable,
   input  wire serial_port_pkg::mode_t mode,
   input  wire logic       rx_enable,
   input  wire logic       slave_select_low_detect_enable,
   input  wire logic       slave_preload_enable,
   input  wire logic       halt_on_debug,
   input  wire logic       debug_mode,
   input  wire logic       auto_baud_enable,
   input  wire logic       collision_detect_enable,
   input  wire logic       bus_clk_slower,
   input  wire logic       run_in_standby,
   input  wire logic       standby,
   input  wire logic [1:0] rx_pad_select,
   input  wire logic [1:0] tx_pad_select,
   input  wire logic       high_speed,
   input  wire logic       quick_command_enable,
   input  wire logic       scl_stretch_select,
   input  wire logic       slave_ten_bit,
   input  wire logic [6:0] slave_address,
   // Receiver and line events
   input  wire logic       stop_bit_missing,
   input  wire logic       sync_field_error,
   input  wire logic       collision_seen,
   input  wire logic       nack_received,
   input  wire logic       byte_sent,
   input  wire logic       addr_byte_valid,
   input  wire logic [7:0] addr_byte,
   input  wire logic       hold_event,
   input  wire logic       hold_release,
   input  wire logic [4:0] err_event,
   // DMA source
   input  wire logic       dma_byte_valid,
   input  wire logic [7:0] dma_byte,
   // Software strobes
   input  wire logic       cmd_write,
   input  wire logic [1:0] cmd_code,
   input  wire logic       addr_write,
   input  wire logic       addr_ten_bit,
   input  wire logic       addr_read,
   input  wire logic       hold_write,
   input  wire logic       hold_write_value,
   input  wire logic       ssl_clear,
   input  wire logic       isf_clear,
   input  wire logic       framing_error_flag_clear,
   input  wire logic       address_match_flag_clear,
   input  wire logic [4:0] err_clear,
   input  wire logic       tx_write,
   input  wire logic [7:0] tx_byte,
   // Pins
   input  wire logic       spi_sck,
   input  wire logic       ss_n_pin,
   input  wire logic       rx_pin,
   output logic            miso_o,
   output logic            miso_oe,
   // Status flags
   output logic            slave_select_low_flag,
   output logic            inconsistent_sync_flag,
   output logic            framing_error_flag,
   output logic            address_match_flag,
   output logic [4:0]      err_flags,
   output logic            scl_hold_status,
   // Actions and status
   output logic            issue_start,
   output logic            issue_rep_start,
   output logic            issue_stop,
   output logic            transfer_abort,
   output logic            dma_take,
   output logic            byte_lost,
   output logic [7:0]      data_reg,
   output logic            tx_running,
   output logic            gclk_request
);

   // ==========================================
   // Mode decode helpers
   function automatic logic is_spi(input serial_port_pkg::mode_t m);
      return (m == serial_port_pkg::MODE_SPI_SLAVE) || (m == serial_port_pkg::MODE_SPI_MASTER);
   endfunction

   function automatic logic is_i2c(input serial_port_pkg::mode_t m);
      return (m == serial_port_pkg::MODE_I2C_SLAVE) || (m == serial_port_pkg::MODE_I2C_MASTER);
   endfunction

   logic       ss_level;
   logic       rx_level;
   logic       full_level;
   logic       ss_prev;
   logic       en_prev;
   logic       ss_fall;
   logic       ss_rise;
   logic       usart;
   logic       i2c_slave;
   logic       lose_now;
   logic       data_empty;
   logic       saw_full;
   logic       dummy_next;
   logic [7:0] tx_word;
   logic [7:0] tx_offer;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic       frame_full;
   logic       last_read;
   logic       last_ten;
   logic       bus_err_now;
   logic       next_rep_start;
   logic       next_stop;
   logic       next_start;
   serial_port_pkg::master_state_t state;
   serial_port_pkg::master_state_t next_state;

   // ==========================================
   // Pin and cross-domain synchronisers
   pin_sync3 #(.INIT(1'b1)) u_ss_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (ss_n_pin),
      .level   (ss_level)
   );

   pin_sync3 #(.INIT(1'b1)) u_rx_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (rx_pin),
      .level   (rx_level)
   );

   pin_sync3 #(.INIT(1'b0)) u_full_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (frame_full),
      .level   (full_level)
   );

   // Edge history for select line and enable
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ss_prev <= 1'b1;
         en_prev <= 1'b0;
      end else begin
         ss_prev <= ss_level;
         en_prev <= unit_enable;
      end
   end

   assign ss_fall   = ss_prev & ~ss_level;
   assign ss_rise   = ~ss_prev & ss_level;
   assign usart     = (mode == serial_port_pkg::MODE_USART);
   assign i2c_slave = (mode == serial_port_pkg::MODE_I2C_SLAVE);

   // ==========================================
   // Select-low flag; enable edge with receive on fires too
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         slave_select_low_flag <= 1'b0;
      end else if (is_spi(mode) && slave_select_low_detect_enable && rx_enable &&
                   unit_enable && ((unit_enable && !en_prev) || ss_fall)) begin
         slave_select_low_flag <= 1'b1;
      end else if (ssl_clear) begin
         slave_select_low_flag <= 1'b0;
      end
   end

   // ==========================================
   // USART receive errors; auto-baud hides missing stop
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         inconsistent_sync_flag <= 1'b0;
         framing_error_flag     <= 1'b0;
      end else begin
         if (usart && auto_baud_enable && sync_field_error) begin
            inconsistent_sync_flag <= 1'b1;
         end else if (isf_clear) begin
            inconsistent_sync_flag <= 1'b0;
         end
         if (usart && !auto_baud_enable && stop_bit_missing) begin
            framing_error_flag <= 1'b1;
         end else if (framing_error_flag_clear) begin
            framing_error_flag <= 1'b0;
         end
      end
   end

   // ==========================================
   // Run, abort and clock request
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_running     <= 1'b0;
         transfer_abort <= 1'b0;
         gclk_request   <= 1'b0;
      end else begin
         tx_running     <= unit_enable && !(debug_mode && halt_on_debug && !usart);
         transfer_abort <= usart && collision_detect_enable && collision_seen &&
                           !bus_clk_slower;
         gclk_request   <= unit_enable && (!standby || run_in_standby ||
                           (usart && !rx_enable && (rx_pad_select != tx_pad_select) &&
                            !rx_level));
      end
   end

   // ==========================================
   // Slave transmit data register fed by DMA
   assign lose_now = i2c_slave && nack_received && dma_byte_valid;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_reg   <= `BYTE_RESET;
         data_empty <= 1'b1;
         dma_take   <= 1'b0;
         byte_lost  <= 1'b0;
      end else begin
         dma_take  <= dma_byte_valid && (data_empty || lose_now);
         byte_lost <= lose_now;
         if (dma_byte_valid && (data_empty || lose_now)) begin
            data_reg <= dma_byte;
         end
         if (byte_sent || lose_now) begin
            data_empty <= 1'b1;
         end else if (dma_byte_valid && data_empty) begin
            data_empty <= 1'b0;
         end
      end
   end

   // ==========================================
   // Clock hold status: set by hardware, writable by software
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         scl_hold_status <= 1'b0;
      end else if (is_i2c(mode) && hold_event) begin
         scl_hold_status <= 1'b1;
      end else if (hold_write) begin
         scl_hold_status <= hold_write_value;
      end else if (hold_release) begin
         scl_hold_status <= 1'b0;
      end
   end

   // ==========================================
   // Slave address match, 7-bit only
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         address_match_flag <= 1'b0;
      end else if (i2c_slave && addr_byte_valid && !slave_ten_bit &&
                   (addr_byte[7:1] == slave_address)) begin
         address_match_flag <= 1'b1;
      end else if (address_match_flag_clear) begin
         address_match_flag <= 1'b0;
      end
   end

   // Error flags cleared only by their own strobes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         err_flags <= `FLAGS_RESET;
      end else begin
         for (int i = 0; i < `ERR_COUNT; i++) begin
            if ((is_i2c(mode) && err_event[i]) || (i == `ERR_BUS && bus_err_now)) begin
               err_flags[i] <= 1'b1;
            end else if (err_clear[i]) begin
               err_flags[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================
   // Master command decode
   always_comb begin
      next_state     = state;
      next_start     = 1'b0;
      next_rep_start = 1'b0;
      next_stop      = 1'b0;
      bus_err_now    = 1'b0;
      if (mode == serial_port_pkg::MODE_I2C_MASTER) begin
         if (addr_write) begin
            next_state = serial_port_pkg::M_OWNER;
            if (state == serial_port_pkg::M_IDLE) begin
               next_start = 1'b1;
            end else if (quick_command_enable && scl_stretch_select) begin
               bus_err_now = 1'b1;
            end else begin
               next_rep_start = 1'b1;
            end
         end else if (cmd_write && state == serial_port_pkg::M_OWNER) begin
            case (cmd_code)
               `CMD_REP_START: begin
                  if (quick_command_enable && scl_stretch_select) begin
                     bus_err_now = 1'b1;
                  end else if (high_speed && !last_read) begin
                     next_stop  = 1'b1;
                     next_state = serial_port_pkg::M_IDLE;
                  end else if (!(last_ten && !last_read && !high_speed)) begin
                     next_rep_start = 1'b1;
                  end
               end
               `CMD_NACK: begin
                  if (high_speed && last_read) begin
                     next_stop  = 1'b1;
                     next_state = serial_port_pkg::M_IDLE;
                  end
               end
               `CMD_STOP: begin
                  next_stop  = 1'b1;
                  next_state = serial_port_pkg::M_IDLE;
               end
               default: next_state = state;
            endcase
         end
      end else begin
         next_state = serial_port_pkg::M_IDLE;
      end
   end

   // Master state and one-cycle action pulses
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state           <= serial_port_pkg::M_IDLE;
         last_read       <= 1'b0;
         last_ten        <= 1'b0;
         issue_start     <= 1'b0;
         issue_rep_start <= 1'b0;
         issue_stop      <= 1'b0;
      end else begin
         state           <= next_state;
         issue_start     <= next_start;
         issue_rep_start <= next_rep_start;
         issue_stop      <= next_stop;
         if (addr_write) begin
            last_read <= addr_read;
            last_ten  <= addr_ten_bit;
         end
      end
   end

   // ==========================================
   // SPI slave preload word and dummy tracking
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_word    <= `BYTE_RESET;
         tx_offer   <= `DUMMY_BYTE;
         saw_full   <= 1'b0;
         dummy_next <= 1'b0;
      end else begin
         if (tx_write) begin
            tx_word <= tx_byte;
         end
         // Offer only changes while select is high
         if (ss_level && ss_prev) begin
            tx_offer <= dummy_next ? `DUMMY_BYTE : tx_word;
         end
         if (ss_fall) begin
            saw_full <= 1'b0;
         end else if (full_level) begin
            saw_full <= 1'b1;
         end
         if (ss_rise && mode == serial_port_pkg::MODE_SPI_SLAVE && slave_preload_enable &&
             !saw_full && !full_level) begin
            dummy_next <= 1'b1;
         end else if (ss_fall) begin
            dummy_next <= 1'b0;
         end
      end
   end

   // ==========================================
   // Link domain: shifter on the master's clock, held clear by select high
   always_ff @(posedge spi_sck or posedge ss_n_pin) begin
      if (ss_n_pin) begin
         bit_cnt    <= 3'h0;
         shreg      <= `BYTE_RESET;
         miso_o     <= 1'b0;
         miso_oe    <= 1'b0;
         frame_full <= 1'b0;
      end else begin
         miso_oe <= 1'b1;
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h0) begin
            miso_o <= tx_offer[7];
            shreg  <= {tx_offer[6:0], 1'b0};
         end else begin
            miso_o <= shreg[7];
            shreg  <= {shreg[6:0], 1'b0};
         end
         if (bit_cnt == `LAST_BIT) begin
            frame_full <= 1'b1; // Whole byte clocked out
         end
      end
   end

endmodule // multi_mode_serial_port_anomalies

`default_nettype wire

// File: mmsp_assertions.sv
// Concurrent checks on the serial port core ports
`timescale 1ns/1ps
`default_nettype none

module mmsp_checker (
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   sys_rst,
   // Configuration
   input wire serial_port_pkg::mode_t mode,
   input wire logic                   unit_enable, rx_enable, slave_select_low_detect_enable,
   input wire logic                   halt_on_debug, debug_mode, auto_baud_enable, standby, run_in_standby,
   input wire logic                   collision_detect_enable, bus_clk_slower, high_speed, slave_ten_bit,
   input wire logic                   quick_command_enable, scl_stretch_select,
   input wire logic [1:0]             rx_pad_select, tx_pad_select, cmd_code,
   // Events and strobes
   input wire logic                   stop_bit_missing, sync_field_error, collision_seen, nack_received,
   input wire logic                   hold_event, dma_byte_valid, cmd_write, addr_write, addr_ten_bit,
   input wire logic                   addr_read, hold_write, hold_write_value, address_match_flag_clear,
   input wire logic [4:0]             err_clear,
   input wire logic [7:0]             dma_byte,
   // Outputs of the core
   input wire logic                   slave_select_low_flag, inconsistent_sync_flag, framing_error_flag,
   input wire logic                   address_match_flag, scl_hold_status, issue_rep_start, transfer_abort,
   input wire logic                   dma_take, byte_lost, tx_running, gclk_request,
   input wire logic [4:0]             err_flags,
   input wire logic [7:0]             data_reg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   wire is_usart = mode == serial_port_pkg::MODE_USART;
   wire is_mst   = mode == serial_port_pkg::MODE_I2C_MASTER;
   wire is_sls   = mode == serial_port_pkg::MODE_I2C_SLAVE;
   logic last_ten;
   logic last_rd;

   // ==========================================
   // Width and direction of the last address write
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         last_ten <= 1'b0;
         last_rd <= 1'b0;
      end else if (addr_write) begin
         last_ten <= addr_ten_bit;
         last_rd <= addr_read;
      end
   end

   // ==========================================
   // Assertions
   a_spurious_ssl: assert property (
      $rose(unit_enable) && mode == serial_port_pkg::MODE_SPI_SLAVE && slave_select_low_detect_enable
      && rx_enable |=> slave_select_low_flag) else $error("no select flag on enable");
   a_autobaud_quiet: assert property (
      is_usart && auto_baud_enable && stop_bit_missing && !sync_field_error && !inconsistent_sync_flag
      && !framing_error_flag |=> !inconsistent_sync_flag && !framing_error_flag) else $error("stop error flagged");
   a_debug_keeps_tx: assert property (
      (is_usart && unit_enable && halt_on_debug && debug_mode) [*2] |-> tx_running) else $error("tx halted");
   a_nack_loses_byte: assert property (
      is_sls && nack_received && dma_byte_valid |=> byte_lost && dma_take && data_reg == $past(dma_byte))
      else $error("nack byte not loaded");
   a_write_no_rep: assert property (
      is_mst && cmd_write && cmd_code == 2'h1 && !addr_write && !last_rd && (high_speed || last_ten)
      |=> !issue_rep_start) else $error("repeated start issued");
   a_hold_writable: assert property (
      hold_write && !hold_event |=> scl_hold_status == $past(hold_write_value)) else $error("hold not written");
   a_ten_no_match: assert property (
      slave_ten_bit && !address_match_flag |=> !address_match_flag) else $error("ten-bit match");
   a_address_match_flag_keeps_err: assert property (
      address_match_flag_clear && err_clear == 5'h00 |=> (err_flags & $past(err_flags)) == $past(err_flags))
      else $error("error flag lost");
   a_bus_clash_flag_abort: assert property (
      is_usart && collision_detect_enable && collision_seen |=> transfer_abort == !$past(bus_clk_slower))
      else $error("abort wrong");
   a_quick_no_rep: assert property (
      (is_mst && quick_command_enable && scl_stretch_select) [*2] |-> !issue_rep_start)
      else $error("quick repeated start");
   a_shared_pad_idle: assert property (
      (unit_enable && standby && !run_in_standby && rx_pad_select == tx_pad_select) [*2] |-> !gclk_request)
      else $error("clock request in standby");
endmodule // mmsp_checker

bind multi_mode_serial_port_anomalies mmsp_checker i_mmsp_checker (.*);

`default_nettype wire

// File: spi_master_model.sv
// Remote SPI master driving the core's slave link
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
   // Link pins toward the core
   output logic      spi_sck,
   output logic      ss_n_pin,
   // Answer from the core
   input  wire logic miso_o,
   input  wire logic miso_oe
);
   // Idle: select high, clock parked low
   initial begin
      spi_sck = 1'b0;
      ss_n_pin = 1'b1;
   end

   // One frame of n clocks at 125 ns; sample on the falling edge
   task automatic xfer(input int n, output logic [7:0] b);
      b = 8'h00;
      ss_n_pin = 1'b0;
      #62.5;
      repeat (n) begin
         spi_sck = 1'b1;
         #62.5;
         b = {b[6:0], miso_oe ? miso_o : 1'bx};
         spi_sck = 1'b0;
         #62.5;
      end
      ss_n_pin = 1'b1;
      #500;
   endtask
endmodule // spi_master_model

`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic ref_clk, sys_rst = 1'b1, rx_pin = 1'b1;
   serial_port_pkg::mode_t mode = serial_port_pkg::MODE_USART;
   logic unit_enable = '0, rx_enable = '0, slave_select_low_detect_enable = '0, slave_preload_enable = '0;
   logic halt_on_debug = '0, debug_mode = '0, auto_baud_enable = '0, collision_detect_enable = '0;
   logic bus_clk_slower = '0, run_in_standby = '0, standby = '0, high_speed = '0, quick_command_enable = '0;
   logic scl_stretch_select = '0, slave_ten_bit = '0, stop_bit_missing = '0, sync_field_error = '0;
   logic collision_seen = '0, nack_received = '0, byte_sent = '0, addr_byte_valid = '0, hold_event = '0;
   logic hold_release = '0, dma_byte_valid = '0, cmd_write = '0, addr_write = '0, addr_ten_bit = '0;
   logic addr_read = '0, hold_write = '0, hold_write_value = '0, ssl_clear = '0, isf_clear = '0;
   logic framing_error_flag_clear = '0, address_match_flag_clear = '0, tx_write = '0;
   logic [1:0] rx_pad_select = '0, tx_pad_select = '0, cmd_code = '0;
   logic [4:0] err_event = '0, err_clear = '0, err_flags;
   logic [6:0] slave_address = 7'h2a;
   logic [7:0] addr_byte = '0, dma_byte = '0, tx_byte = '0, data_reg, b;
   logic miso_o, miso_oe, slave_select_low_flag, inconsistent_sync_flag, framing_error_flag;
   logic address_match_flag, scl_hold_status, issue_start, issue_rep_start, issue_stop;
   logic transfer_abort, dma_take, byte_lost, tx_running, gclk_request;
   wire logic spi_sck, ss_n_pin;
   int error_cnt = 0, checked = 0;

   multi_mode_serial_port_anomalies i_multi_mode_serial_port_anomalies (.*);
   spi_master_model i_spi_master_model (.*);

   // ==========================================
   // Clock and shared tasks
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Master request; exp is {start, repeated start, stop}
   task automatic mreq(input logic a, logic [1:0] c, logic ten, rd, logic [2:0] exp);
      addr_write = a;
      cmd_write = !a;
      cmd_code = c;
      addr_ten_bit = ten;
      addr_read = rd;
      tick();
      addr_write = 1'b0;
      cmd_write = 1'b0;
      chk({issue_start, issue_rep_start, issue_stop}, exp);
      tick();
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog
   initial begin
      #100000;
      error_cnt++;
      tally_and_finish();
   end

   // ==========================================
   // Tests
   initial begin
      tick(6);
      sys_rst = 1'b0;
      tick();
      // Usart: stop bits, debug, collisions, standby
      unit_enable = 1'b1;
      auto_baud_enable = 1'b1;
      stop_bit_missing = 1'b1;
      tick();
      chk({inconsistent_sync_flag, framing_error_flag}, 8'h00);
      auto_baud_enable = 1'b0;
      tick();
      stop_bit_missing = 1'b0;
      chk(framing_error_flag, 8'h01);
      halt_on_debug = 1'b1;
      debug_mode = 1'b1;
      collision_detect_enable = 1'b1;
      bus_clk_slower = 1'b1;
      collision_seen = 1'b1;
      tick();
      chk(transfer_abort, 8'h00);
      bus_clk_slower = 1'b0;
      tick();
      collision_seen = 1'b0;
      chk({transfer_abort, tx_running}, 8'h03);
      standby = 1'b1;
      tx_pad_select = 2'h1;
      rx_pin = 1'b0;
      tick(6);
      chk(gclk_request, 8'h01);
      rx_pin = 1'b1;
      tick(6);
      chk(gclk_request, 8'h00);
      rx_pin = 1'b0;
      tx_pad_select = 2'h0;
      tick(6);
      chk(gclk_request, 8'h00);
      standby = 1'b0;
      debug_mode = 1'b0;
      $display("usart test done");
      // Two-wire slave: errors, address match, hold, dma
      mode = serial_port_pkg::MODE_I2C_SLAVE;
      err_event = 5'h1f;
      addr_byte = 8'h54;
      addr_byte_valid = 1'b1;
      hold_event = 1'b1;
      tick();
      err_event = 5'h00;
      addr_byte_valid = 1'b0;
      hold_event = 1'b0;
      chk({address_match_flag, scl_hold_status}, 8'h03);
      address_match_flag_clear = 1'b1;
      hold_write = 1'b1;
      hold_write_value = 1'b1;
      tick();
      address_match_flag_clear = 1'b0;
      hold_write = 1'b0;
      chk({address_match_flag, scl_hold_status, err_flags}, 8'h3f);
      for (int i = 0; i < 5; i++) begin
         err_clear = 5'h01 << i;
         tick();
         err_clear = 5'h00;
         chk(err_flags, 8'h1f & (8'h3e << i));
         tick();
      end
      slave_ten_bit = 1'b1;
      addr_byte_valid = 1'b1;
      dma_byte = 8'h3c;
      dma_byte_valid = 1'b1;
      tick();
      addr_byte_valid = 1'b0;
      chk({address_match_flag, dma_take}, 8'h01);
      chk(data_reg, 8'h3c);
      tick();
      chk(dma_take, 8'h00);
      dma_byte = 8'h5a;
      nack_received = 1'b1;
      tick();
      nack_received = 1'b0;
      dma_byte_valid = 1'b0;
      chk({byte_lost, data_reg[6:0]}, 8'hda);
      slave_ten_bit = 1'b0;
      $display("two-wire slave test done");
      // Two-wire master commands
      mode = serial_port_pkg::MODE_I2C_MASTER;
      mreq(1'b1, 2'h0, 1'b1, 1'b0, 3'b100);
      mreq(1'b0, 2'h1, 1'b1, 1'b0, 3'b000);
      mreq(1'b1, 2'h0, 1'b1, 1'b0, 3'b010);
      high_speed = 1'b1;
      mreq(1'b0, 2'h1, 1'b0, 1'b0, 3'b001);
      mreq(1'b1, 2'h0, 1'b0, 1'b1, 3'b100);
      mreq(1'b0, 2'h2, 1'b0, 1'b1, 3'b001);
      high_speed = 1'b0;
      mreq(1'b1, 2'h0, 1'b0, 1'b0, 3'b100);
      mreq(1'b0, 2'h1, 1'b0, 1'b0, 3'b010);
      quick_command_enable = 1'b1;
      scl_stretch_select = 1'b1;
      mreq(1'b0, 2'h1, 1'b0, 1'b0, 3'b000);
      chk(err_flags, 8'h10);
      mreq(1'b0, 2'h3, 1'b0, 1'b0, 3'b001);
      quick_command_enable = 1'b0;
      $display("two-wire master test done");
      // Spi slave: enable order and preload
      mode = serial_port_pkg::MODE_SPI_SLAVE;
      unit_enable = 1'b0;
      slave_select_low_detect_enable = 1'b1;
      rx_enable = 1'b1;
      tick();
      unit_enable = 1'b1;
      tick(2);
      chk(slave_select_low_flag, 8'h01);
      ssl_clear = 1'b1;
      unit_enable = 1'b0;
      rx_enable = 1'b0;
      tick();
      ssl_clear = 1'b0;
      unit_enable = 1'b1;
      tick();
      rx_enable = 1'b1;
      slave_preload_enable = 1'b1;
      tx_byte = 8'ha5;
      tx_write = 1'b1;
      tick();
      tx_write = 1'b0;
      tick(4);
      chk(slave_select_low_flag, 8'h00);
      i_spi_master_model.xfer(8, b);
      chk({miso_oe, b[6:0]}, 8'h25);
      i_spi_master_model.xfer(3, b);
      i_spi_master_model.xfer(8, b);
      chk(b, 8'h00);
      i_spi_master_model.xfer(8, b);
      chk(b, 8'ha5);
      $display("spi test done");
      tally_and_finish();
   end
endmodule // tb_top

`default_nettype wire
